// >>> shared/rds_readout_pkg.sv
// shared constants for the tuner channel and radio data readout bank
package rds_readout_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_TUNE_FREQ_INDEX_ERR = 6'h0b;
	localparam logic [5:0] IDX_WORD_A = 6'h0c;
	localparam logic [5:0] IDX_WORD_B = 6'h0d;
	localparam logic [5:0] IDX_WORD_C = 6'h0e;
	localparam logic [5:0] IDX_WORD_D = 6'h0f;
	localparam logic [5:0] IDX_CTRL = 6'h10;
	localparam logic [5:0] IDX_TUNE = 6'h11;
	localparam logic [5:0] IDX_STATUS = 6'h12;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h13;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h14;
	// channel and error readout fields
	localparam int ERR_B_POS = 14;
	localparam int ERR_C_POS = 12;
	localparam int ERR_D_POS = 10;
	localparam int TUNE_FREQ_INDEX_W = 10;
	// control register fields
	localparam int CTRL_VERBOSE_BIT = 0;
	localparam int CTRL_SEEK_BIT = 1;
	localparam int CTRL_TUNE_BIT = 2;
	localparam int CTRL_SPACING_POS = 4;
	localparam int CTRL_BAND_POS = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// status register fields
	localparam int STAT_GROUP_READY_BIT = 15;
	localparam int STAT_DONE_BIT = 14;
	// interrupt bits
	localparam int IRQ_GROUP_BIT = 0;
	localparam int IRQ_DONE_BIT = 1;
	localparam int IRQ_W = 2;
	// reset values
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [TUNE_FREQ_INDEX_W-1:0] TUNE_FREQ_INDEX_RESET = 10'h000;
	// link frame layout
	localparam logic [6:0] GROUP_FRAME_LEN = 7'h47;
	localparam logic [6:0] TUNE_FREQ_INDEX_FRAME_LEN = 7'h0c;
	localparam int FRAME_TYPE_BIT = 70;
	localparam int GROUP_ERR_POS = 64;
	localparam int TUNE_FREQ_INDEX_DONE_BIT = 10;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> logic/group_word_store.sv
// four-word store that holds one decoded group, registered read port
module group_word_store #(
	parameter int WORD_W = 16
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic wr_en_in,
	input wire logic [4*WORD_W-1:0] wr_group_in,
	input wire logic rd_en_in,
	input wire logic [1:0] rd_addr_in,
	output logic [WORD_W-1:0] rd_data_out
);
	logic [WORD_W-1:0] mem_q [4];

	if (WORD_W < 1)
	begin : word_w_check
		$error("WORD_W must be at least 1");
	end

	// whole group written in one cycle so a reader never sees a mix
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < 4; i++)
				mem_q[i] <= '0;
		end
		else if (ce_in && wr_en_in)
		begin
			for (int i = 0; i < 4; i++)
				mem_q[i] <= wr_group_in[(3-i)*WORD_W +: WORD_W];
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rd_data_out <= '0;
		else if (ce_in && rd_en_in)
			rd_data_out <= mem_q[rd_addr_in];
	end
endmodule

// >>> logic/tuner_rds_readout_regs.sv
// channel, block error and radio data group readout bank with bus slave and link
//
// What this block does
// - blocks B, C, D error levels at 15:14, 13:12, 11:10; four severity codes.
// - error level fields hold meaning only while verbose select is one.
// - device stays in reset while the reset pin is low.
// - serial select is active low; serial activity ignored while it is high.
// - timing reference comes from the external reference clock input.
// - group ready flag at status bit 15 rises on a new group.
// - seek or tune control bit driven low clears the seek/tune done flag.
module tuner_rds_readout_regs #(
	parameter int ADDR_W = 8
) (
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	input wire logic CE_IN,
	input wire logic DEVICE_RESET_N_IN,
	input wire logic SERIAL_SELECT_N_IN,
	input wire logic SERIAL_CLK_IN,
	input wire logic SERIAL_DATA_IN,
	output logic SERIAL_DATA_OUT,
	output logic SERIAL_DATA_OE_OUT,
	input wire logic [ADDR_W-1:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [ADDR_W-1:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	output logic [rds_readout_pkg::TUNE_FREQ_INDEX_W-1:0] TUNE_CHANNEL_OUT,
	output logic [1:0] SPACING_OUT,
	output logic [1:0] BAND_OUT,
	output logic SEEK_REQ_OUT,
	output logic TUNE_REQ_OUT,
	output logic IRQ_OUT
);
	import rds_readout_pkg::*;

	// index decode reads address bits 7:2, so narrower buses cannot be served
	if (ADDR_W < 8 || ADDR_W > 32)
	begin : addr_w_check
		$error("ADDR_W must be 8 to 32");
	end

	function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
		return a[7:2];
	endfunction

	function automatic logic mapped(input logic [5:0] idx);
		return idx >= IDX_TUNE_FREQ_INDEX_ERR && idx <= IDX_IRQ_MASK;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic rstn_s1_q, rstn_s2_q, rst;
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q, sel_s1_q, sel_s2_q, sdi_s1_q, sdi_s2_q;
	logic [6:0] bit_cnt_q;
	logic [70:0] shreg_q;
	logic frame_done_q, ack_q;
	logic group_commit, tune_freq_index_commit, frame_full;
	logic [5:0] err_q;
	logic [TUNE_FREQ_INDEX_W-1:0] tune_freq_index_q, tune_idx_q;
	logic [7:0] ctrl_q;
	logic group_ready_q, done_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
	logic aw_full_q, w_full_q, bvalid_q;
	logic [5:0] aw_idx_q, rd_idx_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic rd_busy_q, rd_stage_q, rvalid_q;
	logic [31:0] rdata_q;
	logic [15:0] mem_rdata;
	logic wr_go, ar_take, rd_done;
	logic [15:0] tune_freq_index_err_word;
	logic clr_done_req, rd_clr_irq, rd_clr_group;
	logic [15:0] tune_merged;

	// pin reset caught by two flops; only the bus reset is applied to them
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			rstn_s1_q <= 1'b0;
			rstn_s2_q <= 1'b0;
		end
		else if (CE_IN)
		begin
			rstn_s1_q <= DEVICE_RESET_N_IN;
			rstn_s2_q <= rstn_s1_q;
		end
	end

	assign rst = RESET_IN | ~rstn_s2_q;

	// link pins cross in through two flops each, the link clock through three
	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
		begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
		end
		else if (CE_IN)
		begin
			sclk_s1_q <= SERIAL_CLK_IN;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			sel_s1_q <= SERIAL_SELECT_N_IN;
			sel_s2_q <= sel_s1_q;
			sdi_s1_q <= SERIAL_DATA_IN;
			sdi_s2_q <= sdi_s1_q;
		end
	end

	// frame length depends on the first bit; a short frame is dropped at deselect
	assign frame_full = bit_cnt_q != 7'h00 &&
		bit_cnt_q == (shreg_q[bit_cnt_q - 7'h01] ? TUNE_FREQ_INDEX_FRAME_LEN : GROUP_FRAME_LEN);
	assign group_commit = frame_full && !frame_done_q && !sel_s2_q &&
		bit_cnt_q == GROUP_FRAME_LEN;
	assign tune_freq_index_commit = frame_full && !frame_done_q && !sel_s2_q &&
		bit_cnt_q == TUNE_FREQ_INDEX_FRAME_LEN;

	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
		begin
			bit_cnt_q <= '0;
			shreg_q <= '0;
			frame_done_q <= 1'b0;
			ack_q <= 1'b0;
		end
		else if (CE_IN)
		begin
			if (sel_s2_q)
			begin
				bit_cnt_q <= '0;
				frame_done_q <= 1'b0;
				ack_q <= 1'b0;
			end
			else if (frame_full)
			begin
				frame_done_q <= 1'b1;
				ack_q <= 1'b1;
			end
			else if (sclk_s2_q && !sclk_s3_q)
			begin
				shreg_q <= {shreg_q[69:0], sdi_s2_q};
				bit_cnt_q <= bit_cnt_q + 7'h01;
			end
		end
	end

	// ack drives the shared data line until the host deselects
	assign SERIAL_DATA_OUT = ack_q;
	assign SERIAL_DATA_OE_OUT = ack_q;

	group_word_store #(
		.WORD_W(16)
	) store_u (
		.clk_in(REF_CLK_IN),
		.rst_in(rst),
		.ce_in(CE_IN),
		.wr_en_in(group_commit),
		.wr_group_in(shreg_q[63:0]),
		.rd_en_in(ar_take),
		.rd_addr_in(ARADDR_IN[3:2]),
		.rd_data_out(mem_rdata)
	);

	// errors stored with the group they belong to
	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
			err_q <= '0;
		else if (CE_IN && group_commit)
			err_q <= shreg_q[GROUP_ERR_POS +: 6];
	end

	// readout follows seek steps and the final channel
	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
			tune_freq_index_q <= TUNE_FREQ_INDEX_RESET;
		else if (CE_IN && tune_freq_index_commit)
			tune_freq_index_q <= shreg_q[TUNE_FREQ_INDEX_W-1:0];
	end

	// bus write side
	assign AWREADY_OUT = !aw_full_q && !bvalid_q;
	assign WREADY_OUT = !w_full_q && !bvalid_q;
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;

	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			aw_idx_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bresp_q <= RESP_OKAY;
		end
		else if (CE_IN)
		begin
			if (AWVALID_IN && AWREADY_OUT)
			begin
				aw_full_q <= 1'b1;
				aw_idx_q <= reg_index(AWADDR_IN);
			end
			if (WVALID_IN && WREADY_OUT)
			begin
				w_full_q <= 1'b1;
				wdata_q <= WDATA_IN;
				wstrb_q <= WSTRB_IN;
			end
			if (wr_go)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_q && BREADY_IN)
				bvalid_q <= 1'b0;
		end
	end

	assign BVALID_OUT = bvalid_q;
	assign BRESP_OUT = bresp_q;

	assign tune_merged = merge({6'h00, tune_idx_q}, wdata_q, wstrb_q);

	// writable settings; readout and group words take no write
	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RESET;
			tune_idx_q <= TUNE_FREQ_INDEX_RESET;
			irq_mask_q <= '0;
		end
		else if (CE_IN && wr_go)
		begin
			case (aw_idx_q)
				IDX_CTRL: ctrl_q <= wstrb_q[0] ? wdata_q[7:0] : ctrl_q;
				IDX_TUNE: tune_idx_q <= tune_merged[TUNE_FREQ_INDEX_W-1:0];
				IDX_IRQ_MASK: irq_mask_q <= wstrb_q[0] ? wdata_q[IRQ_W-1:0] : irq_mask_q;
				default: ;
			endcase
		end
	end

	assign TUNE_CHANNEL_OUT = tune_idx_q;
	assign SPACING_OUT = ctrl_q[CTRL_SPACING_POS +: 2];
	assign BAND_OUT = ctrl_q[CTRL_BAND_POS +: 2];
	assign SEEK_REQ_OUT = ctrl_q[CTRL_SEEK_BIT];
	assign TUNE_REQ_OUT = ctrl_q[CTRL_TUNE_BIT];

	// a write that leaves seek or tune low clears done
	assign clr_done_req = wr_go && aw_idx_q == IDX_CTRL && wstrb_q[0] &&
		(!wdata_q[CTRL_SEEK_BIT] || !wdata_q[CTRL_TUNE_BIT]);

	// bus read side; store read adds one cycle
	assign ARREADY_OUT = !rd_busy_q;
	assign ar_take = ARVALID_IN && !rd_busy_q && CE_IN;
	assign rd_done = rvalid_q && RREADY_IN;
	assign rd_clr_irq = rd_stage_q && rd_idx_q == IDX_IRQ_STAT;
	assign rd_clr_group = rd_stage_q && rd_idx_q == IDX_WORD_D;

	// verbose off: error fields read zero
	assign tune_freq_index_err_word = {ctrl_q[CTRL_VERBOSE_BIT] ? err_q : 6'h00, tune_freq_index_q};

	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
		begin
			rd_busy_q <= 1'b0;
			rd_stage_q <= 1'b0;
			rvalid_q <= 1'b0;
			rd_idx_q <= '0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end
		else if (CE_IN)
		begin
			rd_stage_q <= ar_take;
			if (ar_take)
			begin
				rd_busy_q <= 1'b1;
				rd_idx_q <= reg_index(ARADDR_IN);
			end
			if (rd_stage_q)
			begin
				rvalid_q <= 1'b1;
				rresp_q <= mapped(rd_idx_q) ? RESP_OKAY : RESP_SLVERR;
				case (rd_idx_q)
					IDX_TUNE_FREQ_INDEX_ERR: rdata_q <= {16'h0000, tune_freq_index_err_word};
					IDX_WORD_A, IDX_WORD_B, IDX_WORD_C, IDX_WORD_D:
						rdata_q <= {16'h0000, mem_rdata};
					IDX_CTRL: rdata_q <= {24'h000000, ctrl_q};
					IDX_TUNE: rdata_q <= {22'h0, tune_idx_q};
					IDX_STATUS: rdata_q <= {16'h0000, group_ready_q, done_q, 14'h0000};
					IDX_IRQ_STAT: rdata_q <= {30'h0, irq_stat_q};
					IDX_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
					default: rdata_q <= '0;
				endcase
			end
			else if (rd_done)
			begin
				rvalid_q <= 1'b0;
				rd_busy_q <= 1'b0;
			end
		end
	end

	assign RVALID_OUT = rvalid_q;
	assign RDATA_OUT = rdata_q;
	assign RRESP_OUT = rresp_q;

	// flags: a set in the same cycle as a clear wins
	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
		begin
			group_ready_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (CE_IN)
		begin
			if (group_commit)
				group_ready_q <= 1'b1;
			else if (rd_clr_group)
				group_ready_q <= 1'b0;
			if (tune_freq_index_commit && shreg_q[TUNE_FREQ_INDEX_DONE_BIT])
				done_q <= 1'b1;
			else if (clr_done_req)
				done_q <= 1'b0;
		end
	end

	// sticky event bits cleared by reading them
	always_ff @(posedge REF_CLK_IN)
	begin
		if (rst)
			irq_stat_q <= '0;
		else if (CE_IN)
		begin
			irq_stat_q[IRQ_GROUP_BIT] <= group_commit ||
				(irq_stat_q[IRQ_GROUP_BIT] && !rd_clr_irq);
			irq_stat_q[IRQ_DONE_BIT] <= (tune_freq_index_commit && shreg_q[TUNE_FREQ_INDEX_DONE_BIT]) ||
				(irq_stat_q[IRQ_DONE_BIT] && !rd_clr_irq);
		end
	end

	assign IRQ_OUT = |(irq_stat_q & irq_mask_q);
endmodule

// >>> verif/tuner_rds_readout_regs_props.sv
// assertion checker for the readout bank: bus answers, reset pin, link ack
module tuner_rds_readout_regs_props
	import rds_readout_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	input wire logic CE_IN,
	input wire logic DEVICE_RESET_N_IN,
	input wire logic SERIAL_SELECT_N_IN,
	input wire logic SERIAL_DATA_OE_OUT,
	input wire logic [ADDR_W-1:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	input wire logic AWREADY_OUT,
	input wire logic WVALID_IN,
	input wire logic WREADY_OUT,
	input wire logic [1:0] BRESP_OUT,
	input wire logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [ADDR_W-1:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	input wire logic ARREADY_OUT,
	input wire logic [31:0] RDATA_OUT,
	input wire logic [1:0] RRESP_OUT,
	input wire logic RVALID_OUT,
	input wire logic RREADY_IN,
	input wire logic [rds_readout_pkg::TUNE_FREQ_INDEX_W-1:0] TUNE_CHANNEL_OUT,
	input wire logic IRQ_OUT
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RESET_IN);
	logic ar_take;
	logic aw_take;
	assign ar_take = ARVALID_IN && ARREADY_OUT && CE_IN;
	assign aw_take = AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
	chk_read_answer: assert property (ar_take |-> ##[2:3] RVALID_OUT)
		else $error("read request not answered");
	chk_ro_okay: assert property (ar_take && ARADDR_IN[7:2] inside {[IDX_TUNE_FREQ_INDEX_ERR:IDX_WORD_D]}
		|-> ##[1:3] (RVALID_OUT && RRESP_OUT == RESP_OKAY)) else $error("readout read refused");
	chk_unmapped_err: assert property (ar_take && !(ARADDR_IN[7:2] inside
		{[IDX_TUNE_FREQ_INDEX_ERR:IDX_IRQ_MASK]}) |-> ##[1:3] (RVALID_OUT && RRESP_OUT == RESP_SLVERR
		&& RDATA_OUT == 32'h00000000)) else $error("unmapped read not refused");
	chk_upper_zero: assert property (RVALID_OUT |-> RDATA_OUT[31:16] == 16'h0000)
		else $error("upper read data not zero");
	chk_read_close: assert property (RVALID_OUT && RREADY_IN |=> !RVALID_OUT && ARREADY_OUT)
		else $error("read answer not closed");
	chk_write_answer: assert property (aw_take && AWADDR_IN[7:2] inside
		{[IDX_TUNE_FREQ_INDEX_ERR:IDX_IRQ_MASK]} |-> ##[1:3] (BVALID_OUT && BRESP_OUT == RESP_OKAY))
		else $error("mapped write not answered okay");
	chk_write_close: assert property (BVALID_OUT && BREADY_IN |=> !BVALID_OUT && AWREADY_OUT)
		else $error("write answer not closed");
	chk_pin_reset: assert property ((!DEVICE_RESET_N_IN && CE_IN)[*3] |=> !IRQ_OUT
		&& TUNE_CHANNEL_OUT == '0 && !SERIAL_DATA_OE_OUT) else $error("pin reset not applied");
	chk_ack_release: assert property (SERIAL_SELECT_N_IN[*6] |-> !SERIAL_DATA_OE_OUT)
		else $error("link driven while deselected");
	cover property ($rose(IRQ_OUT));
	cover property (RVALID_OUT && RRESP_OUT == RESP_SLVERR);
	cover property ($rose(SERIAL_DATA_OE_OUT));
endmodule
bind tuner_rds_readout_regs tuner_rds_readout_regs_props #(.ADDR_W(ADDR_W))
	i_tuner_rds_readout_regs_props (.REF_CLK_IN, .RESET_IN, .CE_IN, .DEVICE_RESET_N_IN,
	.SERIAL_SELECT_N_IN, .SERIAL_DATA_OE_OUT, .AWADDR_IN, .AWVALID_IN, .AWREADY_OUT,
	.WVALID_IN, .WREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARADDR_IN, .ARVALID_IN,
	.ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT, .RREADY_IN, .TUNE_CHANNEL_OUT, .IRQ_OUT);

// >>> verif/link_sender.sv
// frame source on the far side of the serial link
module link_sender (
	output logic sel_n_out,
	output logic clk_out,
	output logic data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		sel_n_out = 1'b1;
		clk_out = 1'b0;
		data_out = 1'b0;
	end
	// msb first; link clock stands still outside frames
	task automatic send(input int n, input logic [70:0] f, input logic h);
		// edges land on reference clock edges, so change after sampling
		sel_n_out <= h;
		#200;
		for (int i = n - 1; i >= 0; i--)
		begin
			data_out <= f[i];
			#80 clk_out <= 1'b1;
			#80 clk_out <= 1'b0;
		end
		#300 sel_n_out <= 1'b1;
		// no pull on the line, so a released line shows the inverse
		data_out <= ~data_out;
		#100;
	endtask
	// band 11 is not defined, treated like the low band
	function automatic int freq_khz(input logic [1:0] band, input int sp, input logic [9:0] ch);
		return sp * ch + (band == 2'b00 ? 87500 : 76000);
	endfunction
endmodule

// >>> verif/tuner_rds_readout_regs_tb.sv
// self-checking bench for the readout bank: bus, link frames, resets
module tuner_rds_readout_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rds_readout_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pin_n = 1'b1;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, sdo, oe, irq, sel_n, sclk, psd, sd;
	logic [1:0] rresp, bresp, spc, bnd;
	logic skr, tnr;
	int ack_cnt = 0;
	logic [31:0] rdata;
	logic [9:0] tch;
	int err_total = 0, comparisons = 0;
	always #5 clk = ~clk;
	assign sd = oe ? sdo : psd;
	// cycles in which the device pulls the shared line high as ack
	always @(posedge clk)
		if (oe && sd)
			ack_cnt <= ack_cnt + 1;
	tuner_rds_readout_regs i_tuner_rds_readout_regs (.REF_CLK_IN(clk), .RESET_IN(rst),
		.CE_IN(1'b1), .DEVICE_RESET_N_IN(pin_n), .SERIAL_SELECT_N_IN(sel_n),
		.SERIAL_CLK_IN(sclk), .SERIAL_DATA_IN(sd), .SERIAL_DATA_OUT(sdo),
		.SERIAL_DATA_OE_OUT(oe), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
		.AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'h3), .WVALID_IN(wvalid),
		.WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
		.ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
		.RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .TUNE_CHANNEL_OUT(tch),
		.SPACING_OUT(spc), .BAND_OUT(bnd), .SEEK_REQ_OUT(skr), .TUNE_REQ_OUT(tnr),
		.IRQ_OUT(irq));
	link_sender i_link_sender (.sel_n_out(sel_n), .clk_out(sclk), .data_out(psd));
	task automatic close_out;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cmp_freq(input string n, input int e, input int g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("FAIL %s exp %0d got %0d", n, e, g);
		end
	endtask
	// readies are sampled at the falling edge: they only move on rising edges
	// no cycle limit here: only the watchdog ends a wait
	task automatic wr(input logic [5:0] i, input logic [15:0] d,
		input logic [1:0] er = RESP_OKAY);
		logic ta, tw, tb;
		logic [1:0] b;
		ta = 0;
		tw = 0;
		tb = 0;
		b = 2'b00;
		@(posedge clk);
		awaddr <= {i, 2'b00};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb)
		begin
			@(negedge clk);
			ta |= awvalid & awready;
			tw |= wvalid & wready;
			tb = bvalid;
			b = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		cmp("bresp", {14'h0, er}, {14'h0, b});
	endtask
	task automatic rc(input logic [5:0] i, input logic [15:0] e, input logic [1:0] er = RESP_OKAY);
		logic ta, tr;
		logic [15:0] d;
		logic [1:0] r;
		ta = 0;
		tr = 0;
		@(posedge clk);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr)
		begin
			@(negedge clk);
			ta |= arvalid & arready;
			tr = rvalid;
			d = rdata[15:0];
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		cmp("rdata", e, d);
		cmp("rresp", {14'h0, er}, {14'h0, r});
	endtask
	task automatic lk(input int n, input logic [70:0] f, input logic h = 1'b0);
		int a;
		a = ack_cnt;
		i_link_sender.send(n, f, h);
		@(posedge clk);
		cmp("ack", {15'h0, !h}, {15'h0, ack_cnt != a});
		cmp("oe", 16'h0000, {15'h0, oe});
	endtask
	task automatic t_group(input logic v, input logic [5:0] e);
		logic [15:0] w;
		w = {e, 10'h15a};
		wr(IDX_CTRL, {15'h0, v});
		lk(71, {1'b0, e, w, ~w, w + 16'h1, w ^ 16'h00ff});
		cmp("irq", 16'h1, {15'h0, irq});
		rc(IDX_STATUS, 16'h8000);
		rc(IDX_WORD_A, w);
		rc(IDX_WORD_B, ~w);
		rc(IDX_WORD_C, w + 16'h1);
		rc(IDX_WORD_D, w ^ 16'h00ff);
		rc(IDX_TUNE_FREQ_INDEX_ERR, {v ? e : 6'h0, 10'h000});
		rc(IDX_STATUS, 16'h0000);
		rc(IDX_IRQ_STAT, 16'h0001);
		cmp("irq", 16'h0, {15'h0, irq});
		wr(IDX_TUNE_FREQ_INDEX_ERR, 16'hffff);
		wr(IDX_WORD_A, 16'h0000);
		rc(IDX_TUNE_FREQ_INDEX_ERR, {v ? e : 6'h0, 10'h000});
		rc(IDX_WORD_A, w);
	endtask
	task automatic t_tune_freq_index;
		lk(12, {59'h0, 2'b10, 10'h2a5});
		rc(IDX_TUNE_FREQ_INDEX_ERR, 16'h02a5);
		rc(IDX_STATUS, 16'h0000);
		lk(12, {59'h0, 2'b11, 10'h3ff});
		rc(IDX_TUNE_FREQ_INDEX_ERR, 16'h03ff);
		rc(IDX_STATUS, 16'h4000);
		rc(IDX_IRQ_STAT, 16'h0002);
		wr(IDX_CTRL, 16'h0006);
		rc(IDX_STATUS, 16'h4000);
		cmp("seek_req", 16'h0001, {15'h0, skr});
		cmp("tune_req", 16'h0001, {15'h0, tnr});
		wr(IDX_CTRL, 16'h0000);
		rc(IDX_STATUS, 16'h0000);
		cmp_freq("freq", 155200, i_link_sender.freq_khz(bnd, 100, 10'h2a5));
		wr(IDX_CTRL, 16'h0050);
		cmp("band", 16'h0001, {14'h0, bnd});
		cmp("spacing", 16'h0001, {14'h0, spc});
		cmp_freq("freq", 178300, i_link_sender.freq_khz(bnd, 100, 10'h3ff));
		wr(IDX_TUNE, 16'h01c3);
		rc(IDX_TUNE, 16'h01c3);
		cmp("tune", 16'h01c3, {6'h0, tch});
	endtask
	task automatic t_pin;
		pin_n <= 1'b0;
		repeat (8) @(posedge clk);
		pin_n <= 1'b1;
		repeat (4) @(posedge clk);
		cmp("tune", 16'h0000, {6'h0, tch});
		rc(IDX_WORD_A, 16'h0000);
		rc(IDX_IRQ_MASK, 16'h0000);
	endtask
	initial
	begin
		#200000;
		err_total++;
		close_out;
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 5; i++)
			rc(IDX_TUNE_FREQ_INDEX_ERR + 6'(i), 16'h0000);
		rc(IDX_CTRL, {8'h00, CTRL_RESET});
		rc(6'h15, 16'h0000, RESP_SLVERR);
		wr(6'h15, 16'h1234, RESP_SLVERR);
		wr(IDX_IRQ_MASK, 16'h0003);
		rc(IDX_IRQ_MASK, 16'h0003);
		t_group(1'b1, 6'b011011);
		t_group(1'b1, 6'b001101);
		t_group(1'b0, 6'b111111);
		lk(71, {71{1'b1}}, 1'b1);
		rc(IDX_STATUS, 16'h0000);
		rc(IDX_WORD_A, 16'hfd5a);
		t_tune_freq_index;
		t_pin;
		close_out;
	end
endmodule
